// ===== ncai_host.sv
// Host controller driving an 8-bit NAND device one bus cycle at a time.
// Assumes an Avalon-MM master on clk and the device pins behind board wiring.
//
// Operation
// - Address goes in four cycles: column low, column high, row low, row high.
// - Host marks command, address and data input cycles by latches and protect.
// - While the device is busy the host issues only 70h, FFh and reads after 70h.
// - Page read is 00h, address, 30h; device then loads page.
// - Column change in read output is 05, column cycles, E0.
// - Program is 80, address, data, 10h; only 10h starts it.
// - 85h plus two address cycles sets a new data column, repeatable.
// - After 80h the host issues only 85h, 10h or FFh.
`timescale 1ns/1ps
module ncai_host
   import ncai_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             cmd_latch,
   output logic             addr_latch,
   output logic             select_n,
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic             write_protect_n,
   output logic      [7:0]  shared_bus_lines_out,
   output logic             shared_bus_lines_oe_n,
   input  wire logic [7:0]  shared_bus_lines_in,
   input  wire logic        ready_busy_n
);
   ncai_state_t state_reg, state_next;
   ncai_cyc_t   type_reg;
   logic [2:0]  cnt_reg, cnt_next;
   logic [7:0]  byte_reg, rd_byte_reg, last_cmd_reg;
   logic [1:0]  cfg_reg;
   logic        err_reg, prog_open_reg;
   logic [7:0]  bus_sync;
   logic        ready_sync;

   // Pin inputs pass two flops before use
   ncai_sync #(.WIDTH(9), .RESET_VAL(9'h100)) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({ready_busy_n, shared_bus_lines_in}),
      .sync_out ({ready_sync, bus_sync})
   );

   // Bus decode
   wire        req       = avs_read | avs_write;
   wire        acc_wr    = avs_write & ~avs_waitrequest;
   wire        hit_cycle = (avs_address == OFS_CYCLE);
   wire        hit_stat  = (avs_address == OFS_STATUS);
   wire        hit_cfg   = (avs_address == OFS_CONFIG);
   wire        eng_busy  = (state_reg != ST_IDLE);
   wire        stall     = avs_write & hit_cycle & eng_busy;
   wire [31:0] status_w  = {8'h00, last_cmd_reg, rd_byte_reg, 4'h0, prog_open_reg,
                            err_reg, ready_sync, eng_busy};
   wire [31:0] rd_mux    = hit_stat ? status_w :
                           hit_cfg  ? {30'h0, cfg_reg} : 32'h0;

   // New cycle request and its checks
   wire        start    = acc_wr & hit_cycle;
   wire [7:0]  new_byte = avs_writedata[7:0];
   wire [1:0]  new_type = avs_writedata[CYC_TYPE_LSB +: 2];
   wire        is_cmd   = (new_type == CY_CMD);
   wire        is_quiet = is_cmd & ((new_byte == CMD_STATUS) | (new_byte == CMD_RESET));
   wire        ok_busy  = ready_sync | is_quiet |
                          ((new_type == CY_DOUT) & (last_cmd_reg == CMD_STATUS));
   wire        ok_prog  = ~prog_open_reg | ~is_cmd | (new_byte == CMD_COL_WR) |
                          (new_byte == CMD_PROG_GO) | (new_byte == CMD_RESET);
   wire        ok_din   = (new_type != CY_DIN) | cfg_reg[CFG_WP_BIT];
   wire        ok_all   = ok_busy & ok_prog & ok_din & cfg_reg[CFG_SEL_BIT];
   wire        launch   = start & ok_all;
   wire        refuse   = start & ~ok_all;
   wire        err_clr  = acc_wr & hit_stat & avs_writedata[ST_ERR_BIT];
   wire        drive_ph = (state_next == ST_SETUP) | (state_next == ST_STROBE) |
                          (state_next == ST_HOLD);
   // Pins follow the cycle being launched, so setup already shows its latch and byte
   wire [1:0]  pin_type = launch ? new_type : type_reg;
   wire [7:0]  pin_byte = launch ? new_byte : byte_reg;
   wire        is_write = (pin_type != CY_DOUT);

   // Slave answer: one ack cycle per request, cycle writes held off while a cycle runs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest & ~stall);
         if (avs_read & avs_waitrequest)
            avs_readdata <= rd_mux;
      end
   end

   // Software registers and sticky refusal flag, set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= CONFIG_RESET;
         err_reg <= 1'b0;
      end else begin
         if (acc_wr & hit_cfg)
            cfg_reg <= avs_writedata[1:0];
         err_reg <= refuse | (err_reg & ~err_clr);
      end
   end

   // Command history: program-input window and last command
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_cmd_reg  <= CMD_RESET;
         prog_open_reg <= 1'b0;
      end else if (launch & is_cmd) begin
         last_cmd_reg  <= new_byte;
         prog_open_reg <= (new_byte == CMD_SERIAL) |
                          (prog_open_reg & (new_byte == CMD_COL_WR));
      end
   end

   // Engine sequencing: setup, strobe, hold, gap; or setup, read low, gap
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      if (cnt_reg != 3'h0) begin
         cnt_next = cnt_reg - 3'h1;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (launch) begin
                  state_next = ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (type_reg == CY_DOUT) begin
                  state_next = ST_RDLOW;
                  cnt_next   = 3'(RD_LOW_CYC - 1);
               end else begin
                  state_next = ST_STROBE;
                  cnt_next   = 3'(WP_CYC - 1);
               end
            end
            ST_STROBE: begin
               state_next = ST_HOLD;
               cnt_next   = 3'(WH_CYC - 1);
            end
            ST_HOLD, ST_RDLOW: begin
               state_next = ST_GAP;
               cnt_next   = (type_reg == CY_CMD) ? 3'(GAP_CMD_CYC - 1) : 3'(GAP_CYC - 1);
            end
            ST_GAP: begin
               state_next = ST_IDLE;
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   // Engine state, cycle byte and captured read byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 3'h0;
         type_reg    <= CY_CMD;
         byte_reg    <= 8'h00;
         rd_byte_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         if (launch) begin
            type_reg <= ncai_cyc_t'(new_type);
            byte_reg <= new_byte;
         end
         if ((state_reg == ST_RDLOW) && (cnt_reg == 3'h0))
            rd_byte_reg <= bus_sync;
      end
   end

   // Pin drivers, all registered; strobes, latches and bus enable from the next engine state, select and protect from config
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_latch             <= 1'b0;
         addr_latch            <= 1'b0;
         select_n              <= 1'b1;
         write_strobe_n        <= 1'b1;
         read_strobe_n         <= 1'b1;
         write_protect_n       <= 1'b0;
         shared_bus_lines_out  <= 8'h00;
         shared_bus_lines_oe_n <= 1'b1;
      end else begin
         cmd_latch             <= drive_ph & (pin_type == CY_CMD);
         addr_latch            <= drive_ph & (pin_type == CY_ADDR);
         select_n              <= ~cfg_reg[CFG_SEL_BIT];
         write_strobe_n        <= ~(state_next == ST_STROBE);
         read_strobe_n         <= ~(state_next == ST_RDLOW);
         write_protect_n       <= cfg_reg[CFG_WP_BIT];
         shared_bus_lines_out  <= pin_byte;
         shared_bus_lines_oe_n <= ~(drive_ph & is_write);
      end
   end

   // Checks on the pin sequencing, the busy and program-window refusals and the cycle-write stall
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_strobe_pulse;
      !write_strobe_n ##1 write_strobe_n;
   endsequence
   sequence s_read_pulse;
      !read_strobe_n [*4] ##1 read_strobe_n;
   endsequence

   a_cmd_cycle_code: assert property (
      (!write_strobe_n && cmd_latch) |-> (!addr_latch && read_strobe_n && !select_n))
      else $error("command cycle pin code wrong");
   a_addr_cycle_code: assert property (
      (!write_strobe_n && addr_latch) |-> (!cmd_latch && read_strobe_n && !select_n))
      else $error("address cycle pin code wrong");
   a_din_protect_high: assert property (
      (!write_strobe_n && !cmd_latch && !addr_latch) |-> write_protect_n)
      else $error("data input with protect low");
   a_strobe_one_cycle: assert property (
      $fell(write_strobe_n) |-> s_strobe_pulse
                                ##0 ($stable(shared_bus_lines_out) && !shared_bus_lines_oe_n))
      else $error("write strobe pulse or hold wrong");
   a_read_low_len: assert property (
      $fell(read_strobe_n) |-> s_read_pulse)
      else $error("read strobe low width wrong");
   a_read_bus_free: assert property (
      !read_strobe_n |-> (shared_bus_lines_oe_n && write_strobe_n))
      else $error("bus driven during read");
   a_busy_refuse: assert property (
      (start && !ready_sync && !is_quiet && new_type != CY_DOUT) |=>
      (state_reg == ST_IDLE && err_reg) [*2])
      else $error("cycle issued while device busy");
   a_prog_window: assert property (
      (launch && is_cmd && prog_open_reg) |->
      (new_byte == CMD_COL_WR || new_byte == CMD_PROG_GO || new_byte == CMD_RESET))
      else $error("illegal command after serial input");
   a_cmd_gap_ready: assert property (
      ($rose(write_strobe_n) && type_reg == CY_CMD) |-> ##1 (state_reg != ST_IDLE) [*6])
      else $error("command gap shorter than busy window");
   a_stall_answer: assert property (
      (avs_write && hit_cycle && eng_busy) |=> avs_waitrequest)
      else $error("cycle write answered while engine busy");
endmodule

// ===== ncai_nand_model.sv
// NAND device model: command, address, data, status and busy at the pins.
// Assumes the bench resolves the shared bus and pulls the busy line up.
`timescale 1ns/1ps
module ncai_nand_model #(
   parameter int         BUSY_NS = 2000,
   parameter logic [7:0] ID0     = 8'h5a,  // Arbitrary maker value
   parameter logic [7:0] ID1     = 8'h3c,  // Arbitrary part value
   parameter logic [7:0] ID2     = 8'h05   // Two dies, four-level cells
) (
   input  wire logic       cmd_latch,
   input  wire logic       addr_latch,
   input  wire logic       select_n,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic       write_protect_n,
   input  wire logic [7:0] bus_d,
   output logic      [7:0] bus_q,
   output logic            busy_pull
);
   logic [7:0] mem [int];
   logic [7:0] preg [int];
   logic [7:0] q_reg     = 8'h00;
   logic [7:0] last_cmd  = 8'h00;
   logic       prog_open = 1'b0;
   int         col = 0, row = 0, acnt = 0, idx = 0, mode = 0;
   int         ks [$];
   event       kick;
   // Busy line pulled low for a fixed span per operation
   always begin
      busy_pull = 1'b0;
      @kick;
      busy_pull = 1'b1;
      #(BUSY_NS);
   end
   // Command, address or data taken on the write strobe rising edge
   always @(posedge write_strobe_n) begin
      if (!select_n && cmd_latch && !addr_latch) begin
         acnt = 0;
         prog_open = prog_open && (bus_d == 8'h85 || bus_d == 8'h10);
         case (bus_d)
            8'h70: mode = 1;
            8'h90: mode = 2;
            8'h00, 8'he0: mode = 0;
            8'h30: begin
               mode = 0;
               ->kick;
            end
            8'h80: begin
               preg.delete();
               prog_open = 1'b1;
            end
            8'h10: if (prog_open && write_protect_n) begin
               foreach (preg[k]) mem[row * 2112 + k] = preg[k];
               ->kick;
            end
            8'hd0: if (last_cmd == 8'h60 && write_protect_n) begin
               ks.delete();
               foreach (mem[k]) if (k / 135168 == row / 64) ks.push_back(k);
               foreach (ks[i]) mem.delete(ks[i]);
               ->kick;
            end
            8'hff: ->kick;
            default: ;
         endcase
         idx = 0;
         last_cmd = bus_d;
      end else if (!select_n && addr_latch && !cmd_latch) begin
         case (acnt + ((last_cmd == 8'h60) ? 2 : 0))
            0: col = bus_d;
            1: col = col + 256 * bus_d[3:0];
            2: row = bus_d;
            default: row = row + 256 * bus_d;
         endcase
         acnt++;
      end else if (!select_n && !cmd_latch && !addr_latch && write_protect_n && prog_open) begin
         preg[col] = bus_d;
         col++;
      end
   end
   // Next byte on each read strobe falling edge
   always @(negedge read_strobe_n) begin
      if (!select_n && write_strobe_n) begin
         case (mode)
            1: q_reg = {write_protect_n, 1'b0, !busy_pull, 5'h00};
            2: q_reg = (idx == 0) ? ID0 : (idx == 1) ? ID1 : (idx == 2) ? ID2 : 8'h00;
            default: q_reg = mem.exists(row * 2112 + col) ? mem[row * 2112 + col] : 8'hff;
         endcase
         idx++;
         col += (mode == 0);
      end
   end
   // Released bus shows the inverse of the last byte
   assign bus_q = (!select_n && !read_strobe_n) ? q_reg : ~q_reg;
endmodule

// ===== ncai_pkg.sv
// Shared constants for the NAND bus cycle controller: register map, fields,
// command codes, cycle timing and the engine state encoding.
// Assumes a 40 MHz system clock and an 8-bit NAND device on the far side.
package ncai_pkg;

   // Clock and documented minimum pin times
   localparam int CLK_MHZ    = 40;
   localparam int T_WP_NS    = 12;   // Write strobe low width
   localparam int T_WH_NS    = 10;   // Write strobe high hold
   localparam int T_WHR_NS   = 60;   // Write strobe high to read strobe low
   localparam int T_WB_NS    = 100;  // Write strobe high to busy
   localparam int T_REA_NS   = 20;   // Read strobe access time
   localparam int SYNC_STAGES = 2;

   // Least times round up to whole cycles
   localparam int WP_CYC     = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int WH_CYC     = (T_WH_NS * CLK_MHZ + 999) / 1000;
   localparam int WHR_CYC    = (T_WHR_NS * CLK_MHZ + 999) / 1000;
   localparam int WB_CYC     = (T_WB_NS * CLK_MHZ + 999) / 1000;
   localparam int REA_CYC    = (T_REA_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_LOW_CYC = REA_CYC + SYNC_STAGES + 1;
   localparam int GAP_CYC    = WHR_CYC;
   localparam int GAP_CMD_CYC = WB_CYC + SYNC_STAGES;

   // Register byte offsets
   localparam logic [3:0] OFS_CYCLE  = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_CONFIG = 4'h8;

   // Field positions
   localparam int CYC_TYPE_LSB = 8;
   localparam int CFG_WP_BIT   = 0;
   localparam int CFG_SEL_BIT  = 1;
   localparam int ST_ACT_BIT   = 0;
   localparam int ST_RDY_BIT   = 1;
   localparam int ST_ERR_BIT   = 2;
   localparam int ST_PROG_BIT  = 3;
   localparam int ST_BYTE_LSB  = 8;
   localparam int ST_CMD_LSB   = 16;
   localparam logic [1:0] CONFIG_RESET = 2'h0;

   // Bus cycle types
   typedef enum logic [1:0] {
      CY_CMD  = 2'h0,
      CY_ADDR = 2'h1,
      CY_DIN  = 2'h2,
      CY_DOUT = 2'h3
   } ncai_cyc_t;

   // Command codes
   localparam logic [7:0] CMD_READ     = 8'h00;
   localparam logic [7:0] CMD_READ_GO  = 8'h30;
   localparam logic [7:0] CMD_COL_RD   = 8'h05;
   localparam logic [7:0] CMD_COL_RDGO = 8'he0;
   localparam logic [7:0] CMD_SERIAL   = 8'h80;
   localparam logic [7:0] CMD_PROG_GO  = 8'h10;
   localparam logic [7:0] CMD_COL_WR   = 8'h85;
   localparam logic [7:0] CMD_ERASE    = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] CMD_IDENT    = 8'h90;
   localparam logic [7:0] CMD_STATUS   = 8'h70;
   localparam logic [7:0] CMD_RESET    = 8'hff;

   // Engine states, Gray along setup, strobe, hold, gap
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP  = 3'b001,
      ST_STROBE = 3'b011,
      ST_HOLD   = 3'b010,
      ST_GAP    = 3'b110,
      ST_RDLOW  = 3'b111
   } ncai_state_t;

endpackage

// ===== ncai_sync.sv
// Two-flop synchroniser for pin inputs of the NAND controller.
// Assumes inputs change asynchronously to clk; first stage read only by second.
`timescale 1ns/1ps
module ncai_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // Two stages per bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ===== tb.sv
// Self-checking bench: Avalon tasks drive the host, a pin model answers.
// Assumes a 40 MHz clock; expected page bytes come from the bench's own page map, ID and status bytes are constants.
`timescale 1ns/1ps
module tb;
   import ncai_pkg::*;
   logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, busy_pull;
   logic        cmd_latch, addr_latch, select_n, write_strobe_n, read_strobe_n;
   logic        write_protect_n, bus_oe_n;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdata;
   logic [7:0]  bus_out, dev_q, b;
   logic [7:0]  ref_mem [int];
   logic [7:0]  ids [5] = '{8'h5a, 8'h3c, 8'h05, 8'h00, 8'h00};
   wire  [7:0]  bus_pin = !bus_oe_n ? bus_out : dev_q;
   int          num_errors = 0, samples_checked = 0, seed = 36, c, c2, r;
   ncai_host u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
      .select_n(select_n), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .write_protect_n(write_protect_n), .shared_bus_lines_out(bus_out),
      .shared_bus_lines_oe_n(bus_oe_n), .shared_bus_lines_in(bus_pin), .ready_busy_n(!busy_pull));
   ncai_nand_model u_nand (.cmd_latch(cmd_latch), .addr_latch(addr_latch), .select_n(select_n),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .write_protect_n(write_protect_n), .bus_d(bus_pin), .bus_q(dev_q), .busy_pull(busy_pull));
   // Clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic results();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic cyc(input ncai_cyc_t t, input logic [7:0] d);
      bus(1'b1, OFS_CYCLE, {22'h0, t, d});
      do bus(1'b0, OFS_STATUS, 32'h0); while (rdata[ST_ACT_BIT] !== 1'b0);
   endtask
   task automatic rd_byte(input logic [7:0] e);
      cyc(CY_DOUT, 8'h00);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("read byte", rdata[15:8], e);
   endtask
   task automatic err_chk(input logic e);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("error flag", rdata[ST_ERR_BIT], e);
      bus(1'b1, OFS_STATUS, 32'h4);
   endtask
   task automatic wait_ready();
      do bus(1'b0, OFS_STATUS, 32'h0); while (rdata[ST_RDY_BIT] !== 1'b1);
   endtask
   task automatic col2(input int k);
      bus(1'b1, OFS_CYCLE, {22'h0, CY_ADDR, k[7:0]}); // Second write stalls while this runs
      cyc(CY_ADDR, {4'h0, k[11:8]});
   endtask
   task automatic row2(input int k);
      cyc(CY_ADDR, k[7:0]);
      cyc(CY_ADDR, k[15:8]);
   endtask
   task automatic page_read();
      cyc(CY_CMD, CMD_READ);
      col2(c);
      row2(r);
      cyc(CY_CMD, CMD_READ_GO);
   endtask
   // Watchdog
   initial begin
      #2500000;
      num_errors++;
      results();
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("pins", {select_n, write_protect_n, write_strobe_n, read_strobe_n, bus_oe_n}, 5'h17);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status", rdata & 32'h00ff000f, 32'h00ff0002);
      bus(1'b1, 4'hc, 32'h1234);
      bus(1'b0, 4'hc, 32'h0);
      chk("unmapped", rdata, 32'h0);
      cyc(CY_CMD, CMD_RESET);
      err_chk(1'b1);
      bus(1'b1, OFS_CONFIG, 32'h3);
      cyc(CY_CMD, CMD_RESET);
      wait_ready();
      chk("select", {select_n, write_protect_n}, 2'b01);
      cyc(CY_CMD, CMD_IDENT);
      cyc(CY_ADDR, 8'h00);
      foreach (ids[i]) rd_byte(ids[i]);
      err_chk(1'b0);
      c = {$random(seed)} % 1900;
      c2 = c + 150;
      r = {$random(seed)} % 65536;
      cyc(CY_CMD, CMD_SERIAL);
      col2(c);
      row2(r);
      for (int i = 0; i < 6; i++) begin
         if (i == 3) begin
            cyc(CY_CMD, CMD_COL_WR);
            col2(c2);
         end
         b = 8'($random(seed));
         ref_mem[r * 2112 + ((i < 3) ? c + i : c2 + i - 3)] = b;
         cyc(CY_DIN, b);
      end
      cyc(CY_CMD, CMD_READ);
      err_chk(1'b1);
      cyc(CY_CMD, CMD_PROG_GO);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("busy", rdata[ST_RDY_BIT], 1'b0);
      wait_ready();
      cyc(CY_CMD, CMD_STATUS);
      rd_byte(8'ha0);
      page_read();
      cyc(CY_CMD, CMD_ERASE);
      err_chk(1'b1);
      cyc(CY_CMD, CMD_STATUS);
      rd_byte(8'h80);
      wait_ready();
      cyc(CY_CMD, CMD_READ);
      for (int i = 0; i < 3; i++) rd_byte(ref_mem[r * 2112 + c + i]);
      cyc(CY_CMD, CMD_COL_RD);
      col2(c2);
      cyc(CY_CMD, CMD_COL_RDGO);
      for (int i = 0; i < 3; i++) rd_byte(ref_mem[r * 2112 + c2 + i]);
      bus(1'b1, OFS_CONFIG, 32'h2);
      cyc(CY_CMD, CMD_SERIAL);
      cyc(CY_DIN, 8'h00);
      err_chk(1'b1);
      cyc(CY_CMD, CMD_PROG_GO);
      cyc(CY_CMD, CMD_STATUS);
      rd_byte(8'h20);
      bus(1'b1, OFS_CONFIG, 32'h3);
      cyc(CY_CMD, CMD_ERASE);
      cyc(CY_ADDR, r[7:0]);
      cyc(CY_ADDR, r[15:8]);
      cyc(CY_CMD, CMD_ERASE_GO);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("erase busy", rdata[ST_RDY_BIT], 1'b0);
      wait_ready();
      page_read();
      wait_ready();
      rd_byte(8'hff);
      results();
   end
endmodule
